// ==== hdl/video_link_mode_scheduler.sv ====
`timescale 1ns/1ps
`default_nettype none
module video_link_mode_scheduler
  import vlms_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        link_clk,
  input  wire logic        if_select,
  input  wire logic [4:0]  port_variant_straps,
  input  wire logic        ctl_de_wr,
  input  wire logic        ctl_cs_n,
  input  wire logic        video_valid,
  input  wire logic [15:0] video_data,
  input  wire logic        host_valid,
  input  wire logic [15:0] host_data,
  input  wire logic        host_is_cmd,
  input  wire logic        host_is_reg,
  input  wire logic        vblank,
  input  wire logic        hblank,
  input  wire logic        burst_mode,
  input  wire logic [1:0]  virtual_channel_config_reg,
  input  wire logic        nonvideo_low_power_select,
  input  wire logic        blank_lp_select,
  input  wire logic [1:0]  lane_count_select,
  input  wire logic        turn_req,
  input  wire logic        esc_req,
  input  wire logic        esc_rar,
  output logic             mcu_mode_r,
  output logic [1:0]       spi_variant_r,
  output logic [2:0]       mcu_variant_r,
  output logic             reg_wr_r,
  output logic [15:0]      reg_data_r,
  output pkt_t             pkt_r,
  output logic             pkt_valid_r,
  output logic             pkt_lp_r,
  output logic [3:0]       lane_en_r,
  output lane_lines_t      lanes_r,
  output logic [1:0]       clk_lane_r,
  output logic             hs_active_r
);

  // ****************************************************************
  // strap capture and host front end
  // ****************************************************************
  logic       if_sel_s1_r, if_sel_s2_r;
  logic [4:0] straps_s1_r, straps_s2_r;
  logic       cs_s1_r, cs_s2_r;
  logic [1:0] cap_wait_r;
  logic       cap_done_r;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      if_sel_s1_r <= 1'b0;
      if_sel_s2_r <= 1'b0;
      straps_s1_r <= 5'h00;
      straps_s2_r <= 5'h00;
      cs_s1_r     <= 1'b1;
      cs_s2_r     <= 1'b1;
    end
    else if (clk_en)
    begin
      if_sel_s1_r <= if_select;
      if_sel_s2_r <= if_sel_s1_r;
      straps_s1_r <= port_variant_straps;
      straps_s2_r <= straps_s1_r;
      cs_s1_r     <= ctl_cs_n;
      cs_s2_r     <= cs_s1_r;
    end

  // straps are caught once after reset release, then frozen; the wait lets the
  // pin synchronisers fill first, else the reset value would be caught
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      cap_wait_r    <= 2'h0;
      cap_done_r    <= 1'b0;
      mcu_mode_r    <= 1'b0;
      spi_variant_r <= 2'h0;
      mcu_variant_r <= 3'h0;
    end
    else if (clk_en)
    begin
      cap_wait_r <= {cap_wait_r[0], 1'b1};
      if (cap_wait_r[1] && !cap_done_r)
      begin
        cap_done_r    <= 1'b1;
        mcu_mode_r    <= if_sel_s2_r;
        spi_variant_r <= straps_s2_r[1:0];
        mcu_variant_r <= straps_s2_r[4:2];
      end
    end

  // shared strobe serves whichever port is active; idle cs high
  logic host_sel;
  assign host_sel = !cs_s2_r && cap_done_r;

  // ****************************************************************
  // register writes and packet scheduling
  // ****************************************************************
  logic        pend_r;
  logic [15:0] pend_data_r;
  logic        pend_cmd_r;
  logic        burst_r;
  logic        in_blank;
  logic        nv_slot;
  blank_fill_t fill;

  // local register port, independent of the video path
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      reg_wr_r   <= 1'b0;
      reg_data_r <= 16'h0000;
    end
    else if (clk_en)
    begin
      reg_wr_r   <= host_valid && host_sel && host_is_reg && ctl_de_wr;
      reg_data_r <= host_valid ? host_data : reg_data_r;
    end

  // burst setting only taken while no video flows
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      burst_r <= 1'b0;
    else if (clk_en && !video_valid && (vblank || hblank))
      burst_r <= burst_mode;

  assign in_blank = vblank || hblank;
  assign nv_slot  = burst_r ? in_blank : vblank;

  always_comb
  begin
    if (pend_r && nv_slot)
      fill = BL_SEND;
    else if (nonvideo_low_power_select || blank_lp_select || burst_r)
      fill = BL_LP;
    else
      fill = BL_HSBLK;
  end

  logic sent_nv;
  assign sent_nv = clk_en && !video_valid && in_blank && fill == BL_SEND;

  // pending panel data; new arrival wins over the send clear
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      pend_r      <= 1'b0;
      pend_data_r <= 16'h0000;
      pend_cmd_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (host_valid && host_sel && !host_is_reg)
      begin
        pend_r      <= 1'b1;
        pend_data_r <= host_data;
        pend_cmd_r  <= host_is_cmd;
      end
      else if (sent_nv)
        pend_r <= 1'b0;
    end

  // virtual channel on every packet; interleave with video
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      pkt_r       <= '0;
      pkt_valid_r <= 1'b0;
      pkt_lp_r    <= 1'b0;
    end
    else if (clk_en)
    begin
      pkt_valid_r <= 1'b0;
      pkt_lp_r    <= 1'b0;
      pkt_r.vc    <= virtual_channel_config_reg;
      if (video_valid && !in_blank)
      begin
        pkt_valid_r <= 1'b1;
        pkt_r.dtype <= PKT_ID_VID[5:0];
        pkt_r.data  <= video_data;
      end
      else if (in_blank && fill == BL_SEND)
      begin
        pkt_valid_r <= 1'b1;
        pkt_lp_r    <= nonvideo_low_power_select;
        pkt_r.dtype <= pend_cmd_r ? PKT_ID_CMD[5:0] : PKT_ID_GEN[5:0];
        pkt_r.data  <= pend_data_r;
      end
      else if (in_blank && fill == BL_HSBLK)
      begin
        pkt_valid_r <= 1'b1;
        pkt_r.dtype <= PKT_ID_BLK[5:0];
        pkt_r.data  <= 16'h0000;
      end
    end

  // lane enables from the lane field
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      lane_en_r <= 4'h1;
    else if (clk_en)
      lane_en_r <= 4'(({1'b0, 4'hF} << ({1'b0, lane_count_select} + 3'h1)) >> 4) == 4'h0 ?
                   4'hF : ~(4'hF << ({1'b0, lane_count_select} + 3'h1));

  // hs wanted level crosses to the link domain
  logic want_hs_r;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      want_hs_r <= 1'b0;
    else if (clk_en)
      want_hs_r <= (video_valid && !in_blank) || (in_blank && fill != BL_LP &&
                   !(fill == BL_SEND && nonvideo_low_power_select));

  // ****************************************************************
  // link domain lane sequencer
  // ****************************************************************
  logic        hs_s1_r, hs_s2_r, tr_s1_r, tr_s2_r, es_s1_r, es_s2_r;
  logic        rar_s1_r, rar_s2_r;
  logic [3:0]  lane_en_s1_r, lane_en_s2_r;
  link_state_t lk_r;
  logic [2:0]  step_r;
  logic [3:0]  bit_r;
  logic [1:0]  line_r;
  logic        ddr_r;
  logic [7:0]  cmd_r;

  always_ff @(posedge link_clk or posedge rst)
    if (rst)
    begin
      hs_s1_r <= 1'b0;
      hs_s2_r <= 1'b0;
      tr_s1_r <= 1'b0;
      tr_s2_r <= 1'b0;
      es_s1_r <= 1'b0;
      es_s2_r <= 1'b0;
      rar_s1_r <= 1'b0;
      rar_s2_r <= 1'b0;
      lane_en_s1_r <= 4'h1;
      lane_en_s2_r <= 4'h1;
    end
    else
    begin
      hs_s1_r <= want_hs_r;
      hs_s2_r <= hs_s1_r;
      tr_s1_r <= turn_req;
      tr_s2_r <= tr_s1_r;
      es_s1_r <= esc_req;
      es_s2_r <= es_s1_r;
      rar_s1_r <= esc_rar;
      rar_s2_r <= rar_s1_r;
      // lane field is quasi-static, so per-bit sync is enough
      lane_en_s1_r <= lane_en_r;
      lane_en_s2_r <= lane_en_s1_r;
    end

  always_ff @(posedge link_clk or posedge rst)
    if (rst)
    begin
      lk_r   <= LK_STOP;
      step_r <= 3'h0;
      bit_r  <= 4'h0;
      line_r <= LP_11;
      cmd_r  <= ESC_LPDT;
    end
    else
    begin
      step_r <= step_r + 3'h1;
      unique case (lk_r)
        LK_STOP:
        begin
          line_r <= LP_11;
          step_r <= 3'h0;
          // bit count is shared with hs, so start every transfer from zero
          bit_r  <= 4'h0;
          if (hs_s2_r)
            lk_r <= LK_ENTRY;
          else if (tr_s2_r)
            lk_r <= LK_TURN;
          else if (es_s2_r)
          begin
            lk_r  <= LK_ESC;
            cmd_r <= rar_s2_r ? ESC_RAR : ESC_LPDT;
          end
        end
        LK_ENTRY:
        begin
          unique case (step_r)
            3'h0: line_r <= LP_10;
            3'h1: line_r <= LP_00;
            3'h2: line_r <= LP_01;
            default: line_r <= LP_00;
          endcase
          if (step_r == 3'h3)
            lk_r <= LK_HS;
        end
        LK_HS:
        begin
          step_r <= 3'h0;
          line_r <= bit_r[0] ? HS_1 : HS_0;
          bit_r  <= bit_r + 4'h1;
          if (!hs_s2_r)
            lk_r <= LK_EXIT;
        end
        LK_EXIT:
        begin
          line_r <= step_r == 3'h0 ? LP_00 : step_r == 3'h1 ? LP_10 : LP_11;
          if (step_r == 3'h2)
            lk_r <= LK_STOP;
        end
        LK_TURN:
        begin
          // LP-01, LP-00, HS-0, then back to LP-11
          line_r <= step_r == 3'h0 ? LP_01 : step_r == 3'h1 ? LP_00 :
                    step_r == 3'h2 ? HS_0 : LP_11;
          if (step_r == 3'h3)
            lk_r <= LK_STOP;
        end
        LK_ESC:
        begin
          // escape entry LP-10, LP-00, LP-10, LP-00
          if (step_r < 3'h4)
            line_r <= step_r[0] ? LP_00 : LP_10;
          // command bits msb first, spaced one-hot
          else if (step_r == 3'h4)
          begin
            line_r <= cmd_r[7] ? LP_10 : LP_01;
            cmd_r  <= {cmd_r[6:0], 1'b0};
          end
          else
          begin
            step_r <= 3'h4;
            line_r <= LP_00;
            bit_r  <= bit_r + 4'h1;
            if (bit_r == 4'h7)
            begin
              // last space doubles as the first exit step
              bit_r  <= 4'h0;
              lk_r   <= LK_EXIT;
              step_r <= 3'h1;
            end
          end
        end
      endcase
    end

  // ddr clock lane toggles each rising link edge in hs
  always_ff @(posedge link_clk or posedge rst)
    if (rst)
      ddr_r <= 1'b0;
    else
      ddr_r <= lk_r == LK_HS ? !ddr_r : 1'b0;

  // lanes_r and clock lane are link-domain outputs
  always_ff @(posedge link_clk or posedge rst)
    if (rst)
    begin
      lanes_r     <= '{LP_11, LP_11, LP_11, LP_11};
      clk_lane_r  <= LP_11;
      hs_active_r <= 1'b0;
    end
    else
    begin
      lanes_r.st0 <= line_r;
      lanes_r.st1 <= lane_en_s2_r[1] ? line_r : LP_11;
      lanes_r.st2 <= lane_en_s2_r[2] ? line_r : LP_11;
      lanes_r.st3 <= lane_en_s2_r[3] ? line_r : LP_11;
      clk_lane_r  <= lk_r == LK_HS ? (ddr_r ? HS_1 : HS_0) : LP_11;
      hs_active_r <= lk_r == LK_HS;
    end

  // ****************************************************************
  // checks
  // ****************************************************************
  exit_seq_a: assert property (@(posedge link_clk) disable iff (rst)
    lk_r == LK_EXIT && step_r == 3'h0 |=> line_r == LP_00 ##1 line_r == LP_10 ##1
    line_r == LP_11) else $error("bad exit");
  entry_seq_a: assert property (@(posedge link_clk) disable iff (rst)
    lk_r == LK_STOP && hs_s2_r |=> ##1 line_r == LP_10 ##1 line_r == LP_00)
    else $error("bad entry");
  turn_seq_a: assert property (@(posedge link_clk) disable iff (rst)
    lk_r == LK_TURN && step_r == 3'h0 |=> line_r == LP_01 ##1 line_r == LP_00 ##1
    line_r == HS_0) else $error("bad turn");
  stop_rest_a: assert property (@(posedge link_clk) disable iff (rst)
    lk_r == LK_STOP |=> line_r == LP_11) else $error("not stop");
  clk_hs_a: assert property (@(posedge link_clk) disable iff (rst)
    $past(lk_r) == LK_HS && lk_r == LK_HS |=> clk_lane_r != $past(clk_lane_r))
    else $error("no ddr");
  vc_fill_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en |=> pkt_r.vc == $past(virtual_channel_config_reg)) else $error("vc");
  nb_slot_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !burst_r && !vblank && !video_valid |=> !(pkt_valid_r &&
    pkt_r.dtype != PKT_ID_BLK[5:0])) else $error("nv outside vblank");
  lp_mode_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && nonvideo_low_power_select && in_blank && !video_valid |=> !want_hs_r)
    else $error("hs in lp blank");
  hs_blank_c: cover property (@(posedge core_clk) disable iff (rst) fill == BL_HSBLK);
  nv_send_c: cover property (@(posedge core_clk) disable iff (rst) sent_nv);
  esc_cmd_c: cover property (@(posedge link_clk) disable iff (rst) lk_r == LK_ESC);

endmodule // video_link_mode_scheduler
`default_nettype wire

// ==== hdl/vlms_pkg.sv ====
package vlms_pkg;

  // ****************************************************************
  // lane line states {positive, negative}
  // ****************************************************************
  localparam logic [1:0] LP_00 = 2'h0;
  localparam logic [1:0] LP_01 = 2'h1;
  localparam logic [1:0] LP_10 = 2'h2;
  localparam logic [1:0] LP_11 = 2'h3;
  localparam logic [1:0] HS_0  = 2'h1;
  localparam logic [1:0] HS_1  = 2'h2;

  // ****************************************************************
  // escape entry commands, first bit sent first (msb first)
  // ****************************************************************
  localparam logic [7:0] ESC_LPDT = 8'hE1;
  localparam logic [7:0] ESC_RAR  = 8'h62;

  // ****************************************************************
  // sizes and reset values
  // ****************************************************************
  localparam int          LANES      = 4;
  localparam int          SEQ_LEN    = 5;
  localparam logic [1:0]  VC_RST     = 2'h0;
  localparam logic [1:0]  LANE_RST   = 2'h0;
  localparam logic [15:0] PKT_ID_VID = 16'h003E;
  localparam logic [15:0] PKT_ID_GEN = 16'h0029;
  localparam logic [15:0] PKT_ID_CMD = 16'h0039;
  localparam logic [15:0] PKT_ID_BLK = 16'h0019;

  typedef enum logic [5:0] {
    LK_STOP  = 6'b000001,
    LK_ENTRY = 6'b000010,
    LK_HS    = 6'b000100,
    LK_EXIT  = 6'b001000,
    LK_TURN  = 6'b010000,
    LK_ESC   = 6'b100000
  } link_state_t;

  typedef enum logic [2:0] {
    BL_HSBLK = 3'b001,
    BL_LP    = 3'b010,
    BL_SEND  = 3'b100
  } blank_fill_t;

  typedef struct packed {
    logic [1:0]  vc;
    logic [5:0]  dtype;
    logic [15:0] data;
  } pkt_t;

  typedef struct packed {
    logic [1:0] st0;
    logic [1:0] st1;
    logic [1:0] st2;
    logic [1:0] st3;
  } lane_lines_t;

endpackage

// ==== verif/panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module panel_model
  import vlms_pkg::*;
(
  input wire logic        link_clk,
  input wire lane_lines_t lanes_r,
  input wire logic [1:0]  clk_lane_r,
  input wire logic [3:0]  lane_en_r
);
  // ********
  // receiver side of the link
  // ********
  logic [1:0] q[$];
  logic [1:0] last_clk;
  int         clk_flips;
  int         idle_bad;

  initial
  begin
    last_clk = LP_11;
    clk_flips = 0;
    idle_bad = 0;
  end

  // sampled mid link cycle so the sender's edge has settled
  always @(negedge link_clk)
  begin
    // one state per link cycle, frame ends at stop
    if (lanes_r.st0 !== LP_11)
      q.push_back(lanes_r.st0);
    if (clk_lane_r !== last_clk && clk_lane_r !== LP_11 && last_clk !== LP_11)
      clk_flips++;
    last_clk = clk_lane_r;
    if (!lane_en_r[3] && lanes_r.st3 !== LP_11)
      idle_bad++;
  end
endmodule // panel_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
  import vlms_pkg::*;
();
  logic        core_clk, link_clk, rst, if_select, ctl_de_wr, ctl_cs_n, video_valid;
  logic        host_valid, host_is_cmd, host_is_reg, vblank, hblank, burst_mode;
  logic        nonvideo_low_power_select, blank_lp_select, turn_req, esc_req, esc_rar;
  logic        mcu_mode_r, reg_wr_r, pkt_valid_r, pkt_lp_r, hs_active_r;
  logic [4:0]  port_variant_straps;
  logic [15:0] video_data, host_data, reg_data_r;
  logic [1:0]  virtual_channel_config_reg, lane_count_select, spi_variant_r, clk_lane_r;
  logic [2:0]  mcu_variant_r;
  logic [3:0]  lane_en_r;
  pkt_t        pkt_r;
  lane_lines_t lanes_r;
  int          miscompares, comparisons;

  video_link_mode_scheduler uut (
    .core_clk(core_clk), .rst(rst), .clk_en(1'h1), .link_clk(link_clk),
    .if_select(if_select), .port_variant_straps(port_variant_straps),
    .ctl_de_wr(ctl_de_wr), .ctl_cs_n(ctl_cs_n), .video_valid(video_valid),
    .video_data(video_data), .host_valid(host_valid), .host_data(host_data),
    .host_is_cmd(host_is_cmd), .host_is_reg(host_is_reg), .vblank(vblank),
    .hblank(hblank), .burst_mode(burst_mode),
    .virtual_channel_config_reg(virtual_channel_config_reg),
    .nonvideo_low_power_select(nonvideo_low_power_select),
    .blank_lp_select(blank_lp_select), .lane_count_select(lane_count_select),
    .turn_req(turn_req), .esc_req(esc_req), .esc_rar(esc_rar),
    .mcu_mode_r(mcu_mode_r), .spi_variant_r(spi_variant_r),
    .mcu_variant_r(mcu_variant_r), .reg_wr_r(reg_wr_r), .reg_data_r(reg_data_r),
    .pkt_r(pkt_r), .pkt_valid_r(pkt_valid_r), .pkt_lp_r(pkt_lp_r),
    .lane_en_r(lane_en_r), .lanes_r(lanes_r), .clk_lane_r(clk_lane_r),
    .hs_active_r(hs_active_r)
  );

  panel_model panel (
    .link_clk(link_clk), .lanes_r(lanes_r), .clk_lane_r(clk_lane_r), .lane_en_r(lane_en_r)
  );

  // ********
  // clocks and helpers
  // ********
  always #12.5 core_clk = ~core_clk;

  initial
  begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  task automatic test_done();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic fail(input string m);
    miscompares++;
    $display("BAD %0t timeout %s", $time, m);
    test_done();
  endtask

  task automatic wfor(ref logic s, input int n);
    repeat (n)
    begin
      @(negedge core_clk);
      if (s === 1'h1)
        return;
    end
    fail("wait");
  endtask

  // lanes back in stop after a recorded frame
  task automatic wstop();
    repeat (3000)
    begin
      @(negedge core_clk);
      if (panel.q.size() > 0 && lanes_r.st0 === LP_11)
        return;
    end
    fail("stop");
  endtask

  task automatic do_reset(input logic sel, input logic [4:0] ps);
    @(negedge core_clk);
    rst = 1'h1;
    if_select = sel;
    port_variant_straps = ps;
    repeat (10) @(negedge core_clk);
    rst = 1'h0;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic hword(input logic [15:0] d, input logic cmd, input logic rg);
    @(negedge core_clk);
    host_data = d;
    host_is_cmd = cmd;
    host_is_reg = rg;
    ctl_cs_n = 1'h0;
    // chip select must clear its synchroniser before the word is offered
    repeat (3) @(negedge core_clk);
    host_valid = 1'h1;
    ctl_de_wr = 1'h1;
    // one word per valid cycle, so offer it for exactly one edge
    @(negedge core_clk);
    host_valid = 1'h0;
    ctl_de_wr = 1'h0;
  endtask

  task automatic hdone();
    @(negedge core_clk);
    ctl_cs_n = 1'h1;
  endtask

  task automatic quiet();
    repeat (150) @(negedge core_clk);
    panel.q.delete();
    panel.clk_flips = 0;
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_reset(input logic [15:0] e);
    chk({8'h0, lanes_r}, 16'h00FF, "stop");
    chk({4'h0, lane_en_r, clk_lane_r, spi_variant_r, mcu_variant_r, mcu_mode_r}, e, "cfg");
  endtask

  task automatic t_reg();
    hword(16'hA55A, 1'h0, 1'h1);
    chk({15'h0, reg_wr_r}, 16'h1, "regwr");
    chk(reg_data_r, 16'hA55A, "reg");
    hdone();
  endtask

  task automatic t_video(input logic [1:0] vc);
    @(negedge core_clk);
    virtual_channel_config_reg = vc;
    video_data = 16'h7E00 + 16'(vc);
    video_valid = 1'h1;
    wfor(pkt_valid_r, 30);
    chk({pkt_r.vc, pkt_r.dtype, 8'h0}, {vc, PKT_ID_VID[5:0], 8'h0}, "vid");
    chk(pkt_r.data, 16'h7E00 + 16'(vc), "vdat");
    video_valid = 1'h0;
  endtask

  task automatic t_nonburst();
    int n;
    n = 0;
    @(negedge core_clk);
    burst_mode = 1'h0;
    blank_lp_select = 1'h0;
    nonvideo_low_power_select = 1'h0;
    hblank = 1'h1;
    hword(16'h0C0D, 1'h0, 1'h0);
    repeat (10) @(negedge core_clk);
    hdone();
    repeat (40)
    begin
      @(negedge core_clk);
      if (pkt_valid_r === 1'h1 && pkt_r.dtype === PKT_ID_GEN[5:0])
        n++;
    end
    chk(16'(n), 16'h0, "hblank");
    hblank = 1'h0;
    vblank = 1'h1;
    wfor(pkt_valid_r, 60);
    chk({pkt_r.dtype, 9'h0, pkt_lp_r}, {PKT_ID_GEN[5:0], 10'h0}, "gen");
    chk(pkt_r.data, 16'h0C0D, "gdat");
    wfor(pkt_valid_r, 60);
    chk({10'h0, pkt_r.dtype}, {10'h0, PKT_ID_BLK[5:0]}, "blk");
    vblank = 1'h0;
  endtask

  task automatic t_modes();
    int i;
    for (i = 0; i < 3; i++)
    begin
      @(negedge core_clk);
      blank_lp_select = (i == 0);
      nonvideo_low_power_select = (i == 1);
      burst_mode = (i == 2);
      vblank = 1'h1;
      repeat (20) @(negedge core_clk);
      vblank = (i != 2);
      hblank = (i == 2);
      hword(16'h1230 + 16'(i), 1'h1, 1'h0);
      wfor(pkt_valid_r, 100);
      chk({pkt_r.dtype, 9'h0, pkt_lp_r}, {PKT_ID_CMD[5:0], 9'h0, 1'(i == 1)}, "mode");
      chk(pkt_r.data, 16'h1230 + 16'(i), "mdat");
      hdone();
      hblank = 1'h0;
      vblank = 1'h0;
    end
  endtask

  task automatic t_lanes();
    int k;
    for (k = 0; k < 4; k++)
    begin
      lane_count_select = 2'(3 - k);
      repeat (40) @(negedge core_clk);
      chk({12'h0, lane_en_r}, 16'((1 << (4 - k)) - 1), "lanes");
    end
  endtask

  task automatic t_hs();
    quiet();
    burst_mode = 1'h0;
    blank_lp_select = 1'h1;
    video_data = 16'h5AA5;
    video_valid = 1'h1;
    wfor(hs_active_r, 400);
    // keep the burst long enough for several clock lane flips
    repeat (40) @(negedge core_clk);
    video_valid = 1'h0;
    wstop();
    chk({8'h0, panel.q[0], panel.q[1], panel.q[2], panel.q[3]},
        {8'h0, LP_10, LP_00, LP_01, LP_00}, "sot");
    chk({12'h0, panel.q[$ - 1], panel.q[$]}, {12'h0, LP_00, LP_10}, "eot");
    chk(16'(panel.clk_flips >= 4), 16'h1, "clk");
    chk(16'(panel.idle_bad), 16'h0, "idle");
  endtask

  task automatic t_turn();
    quiet();
    turn_req = 1'h1;
    repeat (20) @(negedge core_clk);
    turn_req = 1'h0;
    wstop();
    chk({10'h0, panel.q[0], panel.q[1], panel.q[2]}, {10'h0, LP_01, LP_00, HS_0}, "turn");
  endtask

  task automatic t_esc(input logic rar);
    int         i;
    int         n;
    logic [7:0] b;
    n = 0;
    b = 8'h0;
    quiet();
    esc_rar = rar;
    esc_req = 1'h1;
    repeat (20) @(negedge core_clk);
    esc_req = 1'h0;
    wstop();
    chk({8'h0, panel.q[0], panel.q[1], panel.q[2], panel.q[3]},
        {8'h0, LP_10, LP_00, LP_10, LP_00}, "esc");
    for (i = 4; i < panel.q.size(); i++)
      if (panel.q[i] !== LP_00 && n < 8)
      begin
        b = {b[6:0], panel.q[i] === LP_10};
        n++;
      end
    chk({8'h0, b}, {8'h0, rar ? ESC_RAR : ESC_LPDT}, "cmd");
  endtask

  task automatic t_mcu();
    do_reset(1'h1, 5'h0D);
    t_reset({4'h0, 4'h1, LP_11, 2'h1, 3'h3, 1'h1});
    t_reg();
    virtual_channel_config_reg = 2'h3;
    // low-power blanking so no blanking packet hides the command
    blank_lp_select = 1'h1;
    vblank = 1'h1;
    hword(16'hBEEF, 1'h1, 1'h0);
    wfor(pkt_valid_r, 60);
    chk({pkt_r.vc, pkt_r.dtype, 8'h0}, {2'h3, PKT_ID_CMD[5:0], 8'h0}, "mcu");
    hdone();
  endtask

  initial
  begin
    {core_clk, link_clk, rst, if_select, ctl_de_wr, video_valid, host_valid} = 7'h0;
    {host_is_cmd, host_is_reg, vblank, hblank, burst_mode, turn_req, esc_req} = 7'h0;
    {nonvideo_low_power_select, blank_lp_select, esc_rar} = 3'h0;
    ctl_cs_n = 1'h1;
    port_variant_straps = 5'h16;
    {video_data, host_data} = 32'h0;
    virtual_channel_config_reg = 2'h0;
    lane_count_select = 2'h0;
    miscompares = 0;
    comparisons = 0;
    do_reset(1'h0, 5'h16);
    t_reset({4'h0, 4'h1, LP_11, 2'h2, 3'h5, 1'h0});
    t_reg();
    t_video(2'h1);
    t_video(2'h2);
    t_nonburst();
    t_modes();
    t_lanes();
    t_hs();
    t_turn();
    t_esc(1'h0);
    t_esc(1'h1);
    t_mcu();
    test_done();
  end
endmodule // tb
`default_nettype wire
